/* src/reset_and_interrupt_control.sv */
// Function
// - Four reset causes: cold start, watchdog, oscillator, pin
// - Watchdog resets on bad key or timeout
// - Oscillator out of range forces reset
// - Reset pin driven low eight cycles
// - Stay reset while cold, osc fault, pin
// - Reset-source flags survive reset
// - Status cleared, stack pointer set 01h
// - Accumulators A and B cleared only
// - Load vector low, high, then fetch
// - Twenty cycles from release to fetch
// - Control registers return to reset values
// - Two levels, each globally enabled
// - Per-interrupt chain select, fixed position priority
// - Level arbitration apart from chain arbitration
// - Service only after instruction completes
// - Eight system interrupts besides reset
// - Dedicated vector per system interrupt
// - Per-source local enable and readable flag
// - Selectable active edge per external input
// - Ext 1 nonmaskable option, privilege protected
// - Unused external pins as general input, ext 2 and 3 also as output
// - Wake sources for standby and halt
// - Global enables at status bits 3, 2
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module reset_and_interrupt_control (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    // Reset sources
    input  wire logic                      cold_start,
    input  wire logic                      osc_out_of_range,
    input  wire logic                      reset_pin_n_in,
    output logic                           reset_pin_n_out,
    output logic                           reset_pin_oe,
    // Register port
    input  wire rst_irq_pkg::bus_req_type  bus,
    output logic [7:0]                     rdata,
    // Interrupt sources and pins
    input  wire logic [4:0]                periph_irq,
    input  wire logic [2:0]                ext_pin,
    output logic [2:0]                     ext_gpio_out,
    output logic [1:0]                     ext_gpio_oe,
    // CPU side
    input  wire logic                      instr_done,
    input  wire logic                      irq_ack,
    input  wire logic                      low_power,
    input  wire logic                      halt_mode,
    input  wire logic [7:0]                vector_data,
    output logic [15:0]                    vector_addr,
    output logic                           cpu_reset,
    output logic                           first_fetch,
    output logic                           wake,
    output rst_irq_pkg::irq_req_type       irq
);
    rst_irq_pkg::state_type s_q;
    rst_irq_pkg::state_type s_d;
    logic [7:0] raw;
    logic [7:0] edge_hit;
    logic [7:0] ready;
    logic       reset_req;
    logic       wd_fire;
    logic [2:0] hi_idx;
    logic [2:0] lo_idx;
    logic       hi_any;
    logic       lo_any;
    logic [3:0] hi_pos;
    logic [3:0] lo_pos;

    // ------------------------------------------------------------
    // Priority encoder
    // ------------------------------------------------------------
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Combinational next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Watchdog key and timeout
        wd_fire = 1'b0;
        if (s_q.wd_armed && s_q.seq == rst_irq_pkg::SEQ_RUN) begin
            s_d.wd_cnt = s_q.wd_cnt + 24'h000001;
            if (s_q.wd_cnt == rst_irq_pkg::WATCHDOG_TIMEOUT) begin
                wd_fire = 1'b1;
            end
        end
        if (bus.wr && bus.addr == rst_irq_pkg::ADDR_WATCHDOG_KEY) begin
            if (bus.wdata == rst_irq_pkg::WATCHDOG_KEY_FIRST ||
                bus.wdata == rst_irq_pkg::WATCHDOG_KEY_SECOND) begin
                s_d.wd_cnt   = 24'h000000;
                s_d.wd_armed = 1'b1;
            end else begin
                wd_fire = 1'b1;
            end
        end
        reset_req = wd_fire || osc_out_of_range || cold_start || !reset_pin_n_in;

        // Edge detection and pins
        // polarity per input
        for (int i = 0; i < 3; i++) begin
            edge_hit[i] = s_q.ext_ctl[i] ? (ext_pin[i] && !s_q.ext_prev[i])
                                         : (!ext_pin[i] && s_q.ext_prev[i]);
            if (s_q.ext_ctl[i + 3]) begin
                edge_hit[i] = 1'b0;
            end
        end
        edge_hit[7:3] = periph_irq;
        s_d.ext_prev = ext_pin;
        raw = s_q.pending | edge_hit;

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                rst_irq_pkg::ADDR_EXT_CONTROL: s_d.ext_ctl = bus.wdata;
                rst_irq_pkg::ADDR_CHAIN_SELECT: s_d.chain_sel = bus.wdata;
                rst_irq_pkg::ADDR_LOCAL_ENABLE: s_d.local_en = bus.wdata;
                rst_irq_pkg::ADDR_PENDING: raw = (s_q.pending & ~bus.wdata) | edge_hit;
                rst_irq_pkg::ADDR_CPU_STATUS: s_d.cpu_status = bus.wdata & 8'hfc;
                rst_irq_pkg::ADDR_GPIO: s_d.gpio_out = bus.wdata;
                rst_irq_pkg::ADDR_PRIVILEGE: begin
                    if (!s_q.priv_off) begin
                        s_d.nmi_sel = bus.wdata[rst_irq_pkg::BIT_NMI_SELECT];
                    end
                    s_d.priv_off = s_q.priv_off | bus.wdata[rst_irq_pkg::BIT_PRIV_DISABLE];
                end
                rst_irq_pkg::ADDR_SYSTEM_CONTROL_0: begin
                    if (!bus.wdata[rst_irq_pkg::BIT_COLD_START]) begin
                        s_d.sysctl0[rst_irq_pkg::BIT_COLD_START] = 1'b0;
                    end
                    if (!bus.wdata[rst_irq_pkg::BIT_OSC_FAULT]) begin
                        s_d.sysctl0[rst_irq_pkg::BIT_OSC_FAULT] = 1'b0;
                    end
                end
                rst_irq_pkg::ADDR_TIMER1_CONTROL_2: begin
                    if (!bus.wdata[rst_irq_pkg::BIT_WD_OVERFLOW]) begin
                        s_d.timer1_control_2[rst_irq_pkg::BIT_WD_OVERFLOW] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        s_d.pending = raw;

        // Reset read data
        s_d.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                rst_irq_pkg::ADDR_SYSTEM_CONTROL_0: s_d.rdata = s_q.sysctl0;
                rst_irq_pkg::ADDR_TIMER1_CONTROL_2: s_d.rdata = s_q.timer1_control_2;
                rst_irq_pkg::ADDR_EXT_CONTROL: s_d.rdata = s_q.ext_ctl;
                rst_irq_pkg::ADDR_CHAIN_SELECT: s_d.rdata = s_q.chain_sel;
                rst_irq_pkg::ADDR_LOCAL_ENABLE: s_d.rdata = s_q.local_en;
                rst_irq_pkg::ADDR_PENDING: s_d.rdata = s_q.pending;
                rst_irq_pkg::ADDR_CPU_STATUS: s_d.rdata = s_q.cpu_status;
                rst_irq_pkg::ADDR_GPIO: s_d.rdata = {5'h00, ext_pin};
                rst_irq_pkg::ADDR_PRIVILEGE: s_d.rdata = {6'h00, s_q.nmi_sel, s_q.priv_off};
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Arbitration
        // level gated by enables
        ready = s_q.pending & s_q.local_en;
        hi_pos = first_set(ready & s_q.chain_sel);
        lo_pos = first_set(ready & ~s_q.chain_sel);
        hi_idx = hi_pos[2:0];
        lo_idx = lo_pos[2:0];
        hi_any = |(ready & s_q.chain_sel) && s_q.cpu_status[rst_irq_pkg::BIT_LEVEL1_ENABLE];
        lo_any = |(ready & ~s_q.chain_sel) && s_q.cpu_status[rst_irq_pkg::BIT_LEVEL2_ENABLE];
        s_d.wake = |(s_q.pending & (halt_mode ? rst_irq_pkg::WAKE_HALT_MASK
                                              : rst_irq_pkg::WAKE_STANDBY_MASK)) && low_power;
        if (irq_ack && instr_done) begin
            if (s_q.nmi_sel && s_q.pending[0]) begin
                s_d.pending[0] = edge_hit[0];
            end else if (hi_any) begin
                s_d.pending[hi_idx] = edge_hit[hi_idx];
            end else if (lo_any) begin
                s_d.pending[lo_idx] = edge_hit[lo_idx];
            end
        end

        // Reset sequence
        s_d.fetch = 1'b0;
        if (s_q.pin_cnt != 4'h0) begin
            s_d.pin_cnt = s_q.pin_cnt - 4'h1;
        end else begin
            s_d.pin_drive = 1'b0;
        end
        case (s_q.seq)
            rst_irq_pkg::SEQ_HOLD: begin
                if (!reset_req && !s_q.pin_drive) begin
                    s_d.seq     = rst_irq_pkg::SEQ_COUNT;
                    s_d.seq_cnt = 5'h01;
                end
            end
            rst_irq_pkg::SEQ_COUNT: begin
                s_d.seq_cnt = s_q.seq_cnt + 5'h01;
                if (s_q.seq_cnt == rst_irq_pkg::VEC_LOW_AT) begin
                    s_d.program_counter_low = vector_data;
                end
                if (s_q.seq_cnt == rst_irq_pkg::VEC_HIGH_AT) begin
                    s_d.program_counter_high = vector_data;
                end
                if (s_q.seq_cnt == rst_irq_pkg::FETCH_COUNT) begin
                    s_d.seq   = rst_irq_pkg::SEQ_RUN;
                    s_d.fetch = 1'b1;
                end
            end
            rst_irq_pkg::SEQ_RUN: begin
            end
            default: s_d.seq = rst_irq_pkg::SEQ_HOLD;
        endcase
        if (reset_req || rst) begin
            s_d.seq       = rst_irq_pkg::SEQ_HOLD;
            if (!s_q.pin_drive || s_q.seq != rst_irq_pkg::SEQ_HOLD) begin
                s_d.pin_drive = 1'b1;
                s_d.pin_cnt   = rst_irq_pkg::PIN_COUNT;
            end
            s_d.cpu_status    = rst_irq_pkg::CPU_STATUS_RESET;
            s_d.stack_pointer = rst_irq_pkg::STACK_POINTER_RESET;
            s_d.acc_a = rst_irq_pkg::ACCUMULATOR_RESET;
            s_d.acc_b = rst_irq_pkg::ACCUMULATOR_RESET;
            s_d.ext_ctl   = 8'h00;
            s_d.chain_sel = 8'h00;
            s_d.local_en  = 8'h00;
            s_d.pending   = 8'h00;
            s_d.gpio_out  = 8'h00;
            s_d.nmi_sel   = 1'b0;
            s_d.priv_off  = 1'b0;
            s_d.wd_armed  = 1'b0;
            s_d.wd_cnt    = 24'h000000;
            if (cold_start) begin
                s_d.sysctl0[rst_irq_pkg::BIT_COLD_START] = 1'b1;
            end
            if (osc_out_of_range) begin
                s_d.sysctl0[rst_irq_pkg::BIT_OSC_FAULT] = 1'b1;
            end
            if (wd_fire) begin
                s_d.timer1_control_2[rst_irq_pkg::BIT_WD_OVERFLOW] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        s_q <= s_d;
        if (rst) begin
            s_q.seq     <= rst_irq_pkg::SEQ_HOLD;
            s_q.sysctl0 <= 8'h80;
            s_q.timer1_control_2  <= 8'h00;
            s_q.rdata   <= 8'h00;
            s_q.fetch   <= 1'b0;
            s_q.wake    <= 1'b0;
            s_q.program_counter_low  <= 8'h00;
            s_q.program_counter_high <= 8'h00;
            s_q.ext_prev <= 3'h0;
            s_q.seq_cnt   <= 5'h00;
            s_q.ext_ctl   <= 8'h00;
            s_q.chain_sel <= 8'h00;
            s_q.local_en  <= 8'h00;
            s_q.pending   <= 8'h00;
            s_q.cpu_status    <= rst_irq_pkg::CPU_STATUS_RESET;
            s_q.stack_pointer <= rst_irq_pkg::STACK_POINTER_RESET;
            s_q.acc_a     <= rst_irq_pkg::ACCUMULATOR_RESET;
            s_q.acc_b     <= rst_irq_pkg::ACCUMULATOR_RESET;
            s_q.gpio_out  <= 8'h00;
            s_q.nmi_sel   <= 1'b0;
            s_q.priv_off  <= 1'b0;
            s_q.wd_armed  <= 1'b0;
            s_q.wd_cnt    <= 24'h000000;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // level arbitration output
    always_comb begin
        irq.nmi        = s_q.nmi_sel && s_q.pending[0];
        irq.irq_level1 = hi_any || irq.nmi;
        irq.irq_level2 = lo_any;
        if (irq.nmi) begin
            irq.vector = rst_irq_pkg::VECTOR_TABLE[0];
        end else if (hi_any) begin
            irq.vector = rst_irq_pkg::VECTOR_TABLE[hi_idx];
        end else begin
            irq.vector = rst_irq_pkg::VECTOR_TABLE[lo_idx];
        end
        if (s_q.seq == rst_irq_pkg::SEQ_COUNT && s_q.seq_cnt < rst_irq_pkg::VEC_HIGH_AT) begin
            vector_addr = rst_irq_pkg::RESET_VECTOR_LOW;
        end else if (s_q.seq == rst_irq_pkg::SEQ_COUNT) begin
            vector_addr = rst_irq_pkg::RESET_VECTOR_HIGH;
        end else begin
            vector_addr = {s_q.program_counter_high, s_q.program_counter_low};
        end
    end
    assign reset_pin_n_out = 1'b0;
    assign reset_pin_oe    = s_q.pin_drive;
    assign rdata           = s_q.rdata;
    assign cpu_reset       = s_q.seq != rst_irq_pkg::SEQ_RUN;
    assign first_fetch     = s_q.fetch;
    assign wake            = s_q.wake;
    assign ext_gpio_out    = s_q.gpio_out[2:0];
    assign ext_gpio_oe     = s_q.gpio_out[7:6] & s_q.ext_ctl[5:4];
endmodule

/* include/rst_irq_pkg.sv */
package rst_irq_pkg;
    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_SYSTEM_CONTROL_0   = 16'h1010;
    localparam logic [15:0] ADDR_TIMER1_CONTROL_2   = 16'h104a;
    localparam logic [15:0] ADDR_EXT_CONTROL        = 16'h1017;
    localparam logic [15:0] ADDR_CHAIN_SELECT       = 16'h1018;
    localparam logic [15:0] ADDR_PRIVILEGE          = 16'h1012;
    localparam logic [15:0] ADDR_WATCHDOG_KEY       = 16'h1049;
    localparam logic [15:0] ADDR_PENDING            = 16'h1019;
    localparam logic [15:0] ADDR_LOCAL_ENABLE       = 16'h101a;
    localparam logic [15:0] ADDR_CPU_STATUS         = 16'h101b;
    localparam logic [15:0] ADDR_GPIO               = 16'h101c;
    localparam int          BIT_COLD_START          = 7;
    localparam int          BIT_OSC_FAULT           = 4;
    localparam int          BIT_WD_OVERFLOW         = 5;
    localparam int          BIT_NMI_SELECT          = 1;
    localparam int          BIT_PRIV_DISABLE        = 0;
    localparam int          BIT_LEVEL2_ENABLE       = 3;
    localparam int          BIT_LEVEL1_ENABLE       = 2;
    // ------------------------------------------------------------
    // Reset values and sequence
    // ------------------------------------------------------------
    localparam logic [7:0]  CPU_STATUS_RESET        = 8'h00;
    localparam logic [7:0]  STACK_POINTER_RESET     = 8'h01;
    localparam logic [7:0]  ACCUMULATOR_RESET       = 8'h00;
    localparam logic [15:0] RESET_VECTOR_HIGH       = 16'h7ffe;
    localparam logic [15:0] RESET_VECTOR_LOW        = 16'h7fff;
    localparam logic [7:0]  WATCHDOG_KEY_FIRST      = 8'h55;
    localparam logic [7:0]  WATCHDOG_KEY_SECOND     = 8'haa;
    localparam int          RESET_PIN_LOW_CYCLES    = 8;
    localparam int          RESET_TO_FETCH_CYCLES   = 20;
    localparam logic [4:0]  FETCH_COUNT             = 5'(RESET_TO_FETCH_CYCLES - 1);
    localparam logic [3:0]  PIN_COUNT               = 4'(RESET_PIN_LOW_CYCLES - 1);
    localparam logic [4:0]  VEC_LOW_AT              = 5'h02;
    localparam logic [4:0]  VEC_HIGH_AT             = 5'h04;
    localparam logic [23:0] WATCHDOG_TIMEOUT        = 24'hffffff;
    // ------------------------------------------------------------
    // Vectors, index 0 = highest priority
    // ------------------------------------------------------------
    localparam logic [15:0] VECTOR_TABLE [8] = '{16'h7ffc, 16'h7ffa, 16'h7ff8, 16'h7ff4,
                                                 16'h7ff2, 16'h7ff0, 16'h7fee, 16'h7fec};
    localparam logic [7:0]  WAKE_HALT_MASK          = 8'h13;
    localparam logic [7:0]  WAKE_STANDBY_MASK       = 8'h1b;

    typedef enum logic [1:0] {
        SEQ_HOLD  = 2'b00,
        SEQ_COUNT = 2'b01,
        SEQ_RUN   = 2'b10
    } seq_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

    typedef struct packed {
        logic        irq_level1;
        logic        irq_level2;
        logic [15:0] vector;
        logic        nmi;
    } irq_req_type;

    typedef struct packed {
        seq_state_type seq;
        logic [4:0]    seq_cnt;
        logic [3:0]    pin_cnt;
        logic          pin_drive;
        logic [7:0]    sysctl0;
        logic [7:0]    timer1_control_2;
        logic [7:0]    ext_ctl;
        logic [7:0]    chain_sel;
        logic [7:0]    local_en;
        logic [7:0]    pending;
        logic [7:0]    cpu_status;
        logic [7:0]    gpio_out;
        logic [2:0]    ext_prev;
        logic          nmi_sel;
        logic          priv_off;
        logic          wd_armed;
        logic [23:0]   wd_cnt;
        logic [7:0]    stack_pointer;
        logic [7:0]    acc_a;
        logic [7:0]    acc_b;
        logic [7:0]    program_counter_low;
        logic [7:0]    program_counter_high;
        logic          fetch;
        logic [7:0]    rdata;
        logic          wake;
    } state_type;
endpackage

/* testbench/rst_irq_chk.sv */
`timescale 1ns/1ps
module rst_irq_chk (
    // Clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst,
    // Reset side
    input wire logic                     cold_start,
    input wire logic                     osc_out_of_range,
    input wire logic                     reset_pin_n_in,
    input wire logic                     reset_pin_n_out,
    input wire logic                     reset_pin_oe,
    // Bus and CPU side
    input wire rst_irq_pkg::bus_req_type bus,
    input wire logic [7:0]               rdata,
    input wire logic                     cpu_reset,
    input wire logic                     first_fetch,
    input wire rst_irq_pkg::irq_req_type irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_pin_level: assert property (reset_pin_oe |-> !reset_pin_n_out) else $error("reset pin driven high");
    a_pin_width: assert property ($rose(reset_pin_oe) |-> reset_pin_oe[*8]) else $error("reset pin pulse short");
    a_hold_reset: assert property (cold_start || osc_out_of_range || !reset_pin_n_in |=> cpu_reset)
        else $error("reset not held");
    a_fetch_time: assert property ($fell(reset_pin_oe) && reset_pin_n_in && !osc_out_of_range
        |-> ##[19:21] first_fetch) else $error("fetch timing wrong");
    a_fetch_once: assert property (first_fetch |=> !first_fetch) else $error("fetch pulse long");
    a_fetch_cause: assert property (first_fetch |-> $past(cpu_reset)) else $error("fetch outside reset");
    a_rdata_quiet: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("read data not idle");
    a_no_irq_rst: assert property (cpu_reset && !irq.nmi |-> !irq.irq_level1 && !irq.irq_level2)
        else $error("interrupt during reset");
endmodule
bind reset_and_interrupt_control rst_irq_chk chk_i (.sys_clk, .rst, .cold_start, .osc_out_of_range,
    .reset_pin_n_in, .reset_pin_n_out, .reset_pin_oe, .bus, .rdata, .cpu_reset, .first_fetch, .irq);

/* testbench/cpu_model.sv */
`timescale 1ns/1ps
module cpu_model (
    // Clock
    input wire logic                     sys_clk,
    // Requests from block
    input wire logic [15:0]              vector_addr,
    input wire rst_irq_pkg::irq_req_type irq,
    // Answers
    output logic [7:0]                   vector_data,
    output logic                         instr_done,
    output logic                         irq_ack
);
    // Memory bytes, changing elsewhere
    always_comb vector_data = vector_addr == 16'h7fff ? 8'h34 :
                              vector_addr == 16'h7ffe ? 8'h12 : ~vector_addr[7:0];
    // Instruction ends every other cycle
    initial instr_done = 1'b0;
    always @(posedge sys_clk) instr_done <= ~instr_done;
    assign irq_ack = instr_done & (irq.irq_level1 | irq.irq_level2 | irq.nmi);
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic osc = 1'b0;
    logic ext_rst_n = 1'b1;
    logic [4:0] periph_irq = 5'h00;
    logic [2:0] ext_pin = 3'h0;
    rst_irq_pkg::bus_req_type bus = '0;
    rst_irq_pkg::irq_req_type irq;
    logic [7:0] rdata, vector_data, d;
    logic [15:0] vector_addr;
    logic pin_n_out, pin_oe, cpu_reset, first_fetch, instr_done, irq_ack, pin_n;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int i, n;
    always #20 sys_clk = ~sys_clk;
    assign pin_n = pin_oe ? pin_n_out : ext_rst_n;
    reset_and_interrupt_control reset_and_interrupt_control_i (.sys_clk(sys_clk), .rst(rst),
        .cold_start(1'b0), .osc_out_of_range(osc), .reset_pin_n_in(pin_n), .reset_pin_n_out(pin_n_out),
        .reset_pin_oe(pin_oe), .bus(bus), .rdata(rdata), .periph_irq(periph_irq), .ext_pin(ext_pin),
        .ext_gpio_out(), .ext_gpio_oe(), .instr_done(instr_done), .irq_ack(irq_ack), .low_power(1'b0),
        .halt_mode(1'b0), .vector_data(vector_data), .vector_addr(vector_addr), .cpu_reset(cpu_reset),
        .first_fetch(first_fetch), .wake(), .irq(irq));
    cpu_model cpu_model_i (.sys_clk(sys_clk), .vector_addr(vector_addr), .irq(irq),
        .vector_data(vector_data), .instr_done(instr_done), .irq_ack(irq_ack));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task test_done;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a);
        @(posedge sys_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task wait_fetch;
        for (i = 0; i < 200 && first_fetch !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(16'(first_fetch), 16'h0001);
    endtask
    task wait_vec(input int lvl, input logic [15:0] exp);
        for (i = 0; i < 60 && (lvl == 1 ? irq.irq_level1 : lvl == 2 ? irq.irq_level2 : irq.nmi) !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(vector_addr === vector_addr ? irq.vector : 16'hxxxx, exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_power_up;
        for (i = 0; i < 40 && pin_oe !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        for (n = 0; n < 60 && first_fetch !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        check(16'(n), 16'(rst_irq_pkg::RESET_TO_FETCH_CYCLES));
        check(vector_addr, 16'h1234);
        rd(16'h1010);
        check(16'(d[7]), 16'h0001);
        rd(16'h101b);
        check(16'(d), 16'h0000);
    endtask
    task t_osc_reset;
        wr(16'h1010, 8'h00);
        @(posedge sys_clk);
        osc <= 1'b1;
        repeat (12) @(posedge sys_clk);
        #1 check(16'(cpu_reset), 16'h0001);
        check(16'(pin_oe), 16'h0001);
        @(posedge sys_clk);
        osc <= 1'b0;
        wait_fetch;
        rd(16'h1010);
        check(16'(d & 8'h90), 16'h0010);
    endtask
    task t_pin_reset;
        @(posedge sys_clk);
        ext_rst_n <= 1'b0;
        @(posedge sys_clk);
        ext_rst_n <= 1'b1;
        n = 0;
        for (i = 0; i < 12; i++) begin
            #1 n += int'(pin_oe === 1'b1);
            @(posedge sys_clk);
        end
        check(16'(n >= 8), 16'h0001);
        wait_fetch;
    endtask
    task t_watchdog;
        wr(16'h1049, 8'h55);
        rd(16'h1030);
        check(16'(d), 16'h0000);
        check(16'(cpu_reset), 16'h0000);
        wr(16'h1049, 8'h3c);
        wait_fetch;
        rd(16'h104a);
        check(16'(d[5]), 16'h0001);
    endtask
    task t_irq;
        wr(16'h1017, 8'h01);
        wr(16'h1018, 8'h01);
        wr(16'h101a, 8'h09);
        wr(16'h101b, 8'h0c);
        @(posedge sys_clk);
        ext_pin <= 3'h1;
        wait_vec(1, 16'h7ffc);
        @(posedge sys_clk);
        periph_irq <= 5'h01;
        @(posedge sys_clk);
        periph_irq <= 5'h00;
        wait_vec(2, 16'h7ff4);
        wr(16'h1012, 8'h02);
        wr(16'h101b, 8'h00);
        ext_pin <= 3'h0;
        @(posedge sys_clk);
        ext_pin <= 3'h1;
        wait_vec(3, 16'h7ffc);
    endtask
    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            test_done;
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_power_up;
        t_osc_reset;
        t_pin_reset;
        t_watchdog;
        t_irq;
        test_done;
    end
endmodule
